// ### src/rxs_pkg.sv
package rxs_pkg;
   // ****************************************************
   // widths and limits
   // ****************************************************
   localparam int LEN_W = 16;
   localparam int CNT_W = 32;
   localparam int OCT_W = 48;
   localparam int PORT_W = 6;
   localparam int NUM_CNT = 17;
   localparam int SEL_W = 5;
   localparam logic [LEN_W-1:0] MIN_LEN = 16'h0040;
   localparam logic [LEN_W-1:0] MAX_LEN = 16'h05ee;
   localparam logic [LEN_W-1:0] BIN1_LO = 16'h0041;
   localparam logic [LEN_W-1:0] BIN2_LO = 16'h0080;
   localparam logic [LEN_W-1:0] BIN3_LO = 16'h0100;
   localparam logic [LEN_W-1:0] BIN4_LO = 16'h0200;
   localparam logic [LEN_W-1:0] BIN5_LO = 16'h0400;
   // ****************************************************
   // jabber window
   // ****************************************************
   localparam int CLK_MHZ = 250;
   localparam int JAB_MIN_MS = 20;
   localparam int JAB_MAX_MS = 150;
   localparam int JAB_W = 26;
   localparam longint JAB_MIN_CYC = longint'(JAB_MIN_MS) * CLK_MHZ * 1000;
   localparam longint JAB_MAX_CYC = longint'(JAB_MAX_MS) * CLK_MHZ * 1000;
   // ****************************************************
   // counter select codes
   // ****************************************************
   localparam logic [SEL_W-1:0] SEL_OCTETS = 5'h00;
   localparam logic [SEL_W-1:0] SEL_FRAMES = 5'h01;
   localparam logic [SEL_W-1:0] SEL_BCAST = 5'h02;
   localparam logic [SEL_W-1:0] SEL_MCAST = 5'h03;
   localparam logic [SEL_W-1:0] SEL_CRCALN = 5'h04;
   localparam logic [SEL_W-1:0] SEL_UNDER = 5'h05;
   localparam logic [SEL_W-1:0] SEL_OVER = 5'h06;
   localparam logic [SEL_W-1:0] SEL_FRAG = 5'h07;
   localparam logic [SEL_W-1:0] SEL_JABBER = 5'h08;
   localparam logic [SEL_W-1:0] SEL_COLL = 5'h09;
   localparam logic [SEL_W-1:0] SEL_BIN0 = 5'h0a;
   localparam logic [SEL_W-1:0] SEL_BIN5 = 5'h0f;
   localparam logic [SEL_W-1:0] SEL_OCT_HI = 5'h10;
   // ****************************************************
   // carriers
   // ****************************************************
   typedef struct packed {
      logic valid;
      logic [LEN_W-1:0] len;
      logic fcsBad;
      logic alignBad;
      logic bcast;
      logic mcast;
   } rxs_frame_t;
   typedef struct packed {
      logic valid;
      logic [SEL_W-1:0] sel;
   } rxs_read_t;
endpackage

// ### src/rxs_jabber_timer.sv
`timescale 1ns/1ns
module rxs_jabber_timer (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // receive activity and window length in cycles
   input wire logic rxActive,
   input wire logic [rxs_pkg::JAB_W-1:0] window,
   // window exceeded
   output logic expired
);
   import rxs_pkg::*;
   logic [JAB_W-1:0] count;
   logic [JAB_W-1:0] next_count;
   logic next_expired;
   always_comb begin
      next_count = count;
      next_expired = 1'b0;
      if (!rxActive) begin
         next_count = '0;
      end else if (count >= window) begin
         next_expired = 1'b1;
      end else begin
         next_count = count + 1'b1;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
         expired <= 1'b0;
      end else begin
         count <= next_count;
         expired <= next_expired;
      end
   end
endmodule

// ### src/rxs_port_stats.sv
`timescale 1ns/1ns
module rxs_port_stats (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // frame status from receive path
   input wire rxs_pkg::rxs_frame_t frame,
   input wire logic collision,
   input wire logic rxActive,
   // management
   input wire logic [rxs_pkg::PORT_W-1:0] portId,
   input wire logic [rxs_pkg::PORT_W-1:0] selPort,
   input wire logic clearAll,
   input wire logic [rxs_pkg::JAB_W-1:0] jabWindow,
   input wire rxs_pkg::rxs_read_t rdReq,
   // read answer
   output logic rdValid,
   output logic [rxs_pkg::CNT_W-1:0] rdData
);
   import rxs_pkg::*;
   // ****************************************************
   // event decode
   // ****************************************************
   function automatic logic [NUM_CNT-1:0] classify(input rxs_frame_t f,
                                                   input logic jab);
      logic bad;
      logic [NUM_CNT-1:0] ev;
      bad = f.fcsBad | f.alignBad;
      ev = '0;
      ev[SEL_FRAMES] = f.valid;
      ev[SEL_BCAST] = f.valid & !bad & f.bcast;
      ev[SEL_MCAST] = f.valid & !bad & f.mcast & !f.bcast;
      ev[SEL_CRCALN] = f.valid & bad;
      ev[SEL_UNDER] = f.valid & !bad & (f.len < MIN_LEN);
      ev[SEL_FRAG] = f.valid & bad & (f.len < MIN_LEN);
      ev[SEL_OVER] = f.valid & (f.len > MAX_LEN);
      ev[SEL_JABBER] = f.valid & bad & ((f.len > MAX_LEN) | jab);
      ev[SEL_BIN0] = f.valid & (f.len == MIN_LEN);
      ev[SEL_BIN0+1] = f.valid & (f.len >= BIN1_LO) & (f.len < BIN2_LO);
      ev[SEL_BIN0+2] = f.valid & (f.len >= BIN2_LO) & (f.len < BIN3_LO);
      ev[SEL_BIN0+3] = f.valid & (f.len >= BIN3_LO) & (f.len < BIN4_LO);
      ev[SEL_BIN0+4] = f.valid & (f.len >= BIN4_LO) & (f.len < BIN5_LO);
      ev[SEL_BIN5] = f.valid & (f.len >= BIN5_LO) & (f.len <= MAX_LEN);
      return ev;
   endfunction

   logic clearHit;
   logic jabSeen;
   logic jabExpired;
   logic [JAB_W-1:0] winClamp;
   logic [NUM_CNT-1:0] evt;

   assign clearHit = clearAll & (selPort == portId);
   always_comb begin
      if (jabWindow < JAB_W'(JAB_MIN_CYC)) begin
         winClamp = JAB_W'(JAB_MIN_CYC);
      end else if (jabWindow > JAB_W'(JAB_MAX_CYC)) begin
         winClamp = JAB_W'(JAB_MAX_CYC);
      end else begin
         winClamp = jabWindow;
      end
   end

   rxs_jabber_timer u_rxs_jabber_timer (
      .clock(clock),
      .resetn(resetn),
      .rxActive(rxActive),
      .window(winClamp),
      .expired(jabExpired)
   );

   // ****************************************************
   // jabber flag per frame
   // ****************************************************
   logic next_jabSeen;
   always_comb begin
      next_jabSeen = jabSeen;
      if (frame.valid) begin
         next_jabSeen = 1'b0;
      end else if (jabExpired) begin
         next_jabSeen = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         jabSeen <= 1'b0;
      end else begin
         jabSeen <= next_jabSeen;
      end
   end

   assign evt = classify(frame, jabSeen | jabExpired);

   // ****************************************************
   // counters
   // ****************************************************
   logic [OCT_W-1:0] octets;
   logic [OCT_W-1:0] next_octets;
   logic [CNT_W-1:0] cnt [1:NUM_CNT-1];
   logic [CNT_W-1:0] next_cnt [1:NUM_CNT-1];

   always_comb begin
      next_octets = octets;
      if (clearHit) begin
         next_octets = '0;
      end else if (frame.valid) begin
         next_octets = octets + OCT_W'(frame.len);
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi < NUM_CNT; gi++) begin : gCnt
         logic hit;
         if (gi == SEL_COLL) begin : gColl
            assign hit = collision;
         end else begin : gEvt
            assign hit = evt[gi];
         end
         always_comb begin
            next_cnt[gi] = cnt[gi];
            if (clearHit) begin
               next_cnt[gi] = '0;
            end else if (hit) begin
               next_cnt[gi] = cnt[gi] + 1'b1;
            end
         end
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               cnt[gi] <= '0;
            end else begin
               cnt[gi] <= next_cnt[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         octets <= '0;
      end else begin
         octets <= next_octets;
      end
   end

   // ****************************************************
   // read port
   // ****************************************************
   logic [OCT_W-CNT_W-1:0] octHold;
   logic [OCT_W-CNT_W-1:0] next_octHold;
   logic next_rdValid;
   logic [CNT_W-1:0] next_rdData;

   // octet high 16 bits latched on low read
   always_comb begin
      next_rdValid = rdReq.valid;
      next_rdData = rdData;
      next_octHold = octHold;
      if (rdReq.valid) begin
         if (rdReq.sel == SEL_OCTETS) begin
            next_rdData = octets[CNT_W-1:0];
            next_octHold = octets[OCT_W-1:CNT_W];
         end else if (rdReq.sel == SEL_OCT_HI) begin
            next_rdData = CNT_W'(octHold);
         end else if (rdReq.sel < SEL_OCT_HI) begin
            next_rdData = cnt[rdReq.sel];
         end else begin
            next_rdData = '0;
         end
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdValid <= 1'b0;
         rdData <= '0;
         octHold <= '0;
      end else begin
         rdValid <= next_rdValid;
         rdData <= next_rdData;
         octHold <= next_octHold;
      end
   end
endmodule

// ### test/rxs_mac_model.sv
`timescale 1ns/1ns
module rxs_mac_model (
   // clock
   input wire logic clock,
   // frame status toward the counters
   output rxs_pkg::rxs_frame_t frame,
   output logic collision,
   output logic rxActive
);
   import rxs_pkg::*;
   initial begin
      frame = '0;
      collision = 1'b0;
      rxActive = 1'b0;
   end
   task automatic send(input logic [LEN_W-1:0] len, input logic [3:0] f);
      frame = {1'b1, len, f};
      rxActive = 1'b1;
      @(negedge clock);
      frame = {1'b0, ~frame[19:0]};
      rxActive = 1'b0;
   endtask
   task automatic bump();
      collision = 1'b1;
      @(negedge clock);
      collision = 1'b0;
   endtask
endmodule

// ### test/rxs_port_stats_checker.sv
`timescale 1ns/1ns
module rxs_port_stats_checker (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // frame status
   input wire rxs_pkg::rxs_frame_t frame,
   input wire logic collision,
   // management
   input wire logic [rxs_pkg::PORT_W-1:0] portId,
   input wire logic [rxs_pkg::PORT_W-1:0] selPort,
   input wire logic clearAll,
   input wire rxs_pkg::rxs_read_t rdReq,
   // read answer
   input wire logic rdValid,
   input wire logic [rxs_pkg::CNT_W-1:0] rdData
);
   import rxs_pkg::*;
   wire clr = clearAll && selPort == portId;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence two_rd_s(s, c);
      rdReq.valid && rdReq.sel == s && frame.valid && c && !clr
         ##1 rdReq.valid && rdReq.sel == s;
   endsequence
   AST_RD_LAT: assert property (rdReq.valid |=> rdValid)
      else $error("read answer missing");
   AST_RD_QUIET: assert property (!rdReq.valid |=>
      !rdValid && $stable(rdData)) else $error("read data moved");
   AST_BAD_SEL: assert property (rdReq.valid &&
      rdReq.sel > SEL_OCT_HI |=> rdData == 0) else $error("bad select");
   AST_CLR: assert property (clr ##1 rdReq.valid &&
      rdReq.sel != SEL_OCT_HI |=> rdData == 0) else $error("not cleared");
   AST_KEEP: assert property (rdReq.valid && $past(rdReq.valid) &&
      rdReq.sel == $past(rdReq.sel) && !$past(frame.valid) &&
      !$past(collision) && !$past(clr) && rdReq.sel != SEL_OCT_HI
      |=> rdData == $past(rdData)) else $error("read disturbed count");
   AST_FRAME_CNT: assert property (two_rd_s(SEL_FRAMES, 1'b1)
      |=> rdData == $past(rdData) + 1) else $error("frame count step");
   AST_OCT_CNT: assert property (two_rd_s(SEL_OCTETS, 1'b1)
      |=> rdData == $past(rdData) + $past(frame.len, 2))
      else $error("octet count step");
   AST_BC_NO_MC: assert property (two_rd_s(SEL_BCAST,
      frame.mcast && !frame.bcast) |=> $stable(rdData))
      else $error("multicast in broadcast");
   cover property (clr);
   cover property (collision);
   cover property (rdReq.valid && rdReq.sel == SEL_JABBER);
endmodule
bind rxs_port_stats rxs_port_stats_checker u_rxs_port_stats_checker (
   .clock(clock), .resetn(resetn), .frame(frame), .collision(collision),
   .portId(portId), .selPort(selPort), .clearAll(clearAll),
   .rdReq(rdReq), .rdValid(rdValid), .rdData(rdData));

// ### test/test_rxs_port_stats.sv
`timescale 1ns/1ns
`define CHK(x, y) begin compares++; if ((x) !== (y)) begin n_fail++; \
   $display("CHECK FAILED %0t got %h want %h", $time, x, y); end end
module test_rxs_port_stats;
   import rxs_pkg::*;
   typedef struct packed {
      logic [LEN_W-1:0] len;
      logic [3:0] f;
      logic [SEL_W-1:0] sel;
      logic [7:0] d;
   } rxs_row_t;
   localparam logic [PORT_W-1:0] MY_PORT = 6'h05;
   logic clock;
   logic resetn;
   rxs_frame_t frame;
   logic collision;
   logic rxActive;
   logic [PORT_W-1:0] selPort;
   logic clearAll;
   rxs_read_t rdReq;
   logic rdValid;
   logic [CNT_W-1:0] rdData;
   logic [CNT_W-1:0] a;
   logic [CNT_W-1:0] b;
   int n_fail = 0;
   int compares = 0;
   // length, {fcs, align, bcast, mcast}, select, expected step
   rxs_row_t rows[29] = '{
      '{16'h40,4'h0,5'ha,8'h1}, '{16'h41,4'h0,5'hb,8'h1},
      '{16'h7f,4'h0,5'hb,8'h1}, '{16'h80,4'h0,5'hc,8'h1},
      '{16'h1ff,4'h0,5'hd,8'h1}, '{16'h200,4'h0,5'he,8'h1},
      '{16'h400,4'h0,5'hf,8'h1}, '{16'h5ee,4'h0,5'hf,8'h1},
      '{16'h5ee,4'h0,5'h6,8'h0}, '{16'h5ef,4'h0,5'h6,8'h1},
      '{16'h5ef,4'h0,5'h8,8'h0}, '{16'h5ef,4'h8,5'h8,8'h1},
      '{16'h5ef,4'h4,5'h8,8'h1}, '{16'h3f,4'h0,5'h5,8'h1},
      '{16'h3f,4'h0,5'h7,8'h0}, '{16'h3f,4'h8,5'h7,8'h1},
      '{16'h3f,4'h8,5'h5,8'h0}, '{16'h64,4'h2,5'h2,8'h1},
      '{16'h64,4'ha,5'h2,8'h0}, '{16'h64,4'h1,5'h2,8'h0},
      '{16'h64,4'h1,5'h3,8'h1}, '{16'h64,4'h8,5'h4,8'h1},
      '{16'h64,4'h4,5'h4,8'h1}, '{16'h64,4'hc,5'h1,8'h1},
      '{16'h64,4'hc,5'h0,8'h64}, '{16'h3f,4'h0,5'ha,8'h0},
      '{16'h5ef,4'h0,5'hf,8'h0}, '{16'h64,4'h3,5'h2,8'h1},
      '{16'h64,4'h3,5'h3,8'h0}};
   rxs_port_stats u_rxs_port_stats (.clock(clock), .resetn(resetn),
      .frame(frame), .collision(collision), .rxActive(rxActive),
      .portId(MY_PORT), .selPort(selPort), .clearAll(clearAll),
      .jabWindow(JAB_W'(JAB_MIN_CYC)), .rdReq(rdReq), .rdValid(rdValid),
      .rdData(rdData));
   rxs_mac_model u_rxs_mac_model (.clock(clock), .frame(frame),
      .collision(collision), .rxActive(rxActive));
   task automatic end_of_test();
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // two reads of one counter around an event: 1 frame, 2 collision, 3 clear
   task automatic meas(input rxs_row_t r, input int m);
      @(negedge clock);
      rdReq = '{1'b1, r.sel};
      clearAll = (m == 3);
      if (m == 2) u_rxs_mac_model.bump();
      else if (m != 0) u_rxs_mac_model.send(r.len, r.f);
      else @(negedge clock);
      clearAll = 1'b0;
      a = rdData;
      @(negedge clock);
      b = rdData;
      `CHK(rdValid, 1'b1)
      rdReq.valid = 1'b0;
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
   initial begin
      resetn = 1'b0;
      selPort = MY_PORT;
      clearAll = 1'b0;
      rdReq = '0;
      repeat (16) @(negedge clock);
      `CHK(rdData, 32'h0)
      `CHK(rdValid, 1'b0)
      resetn = 1'b1;
      foreach (rows[i]) begin
         meas(rows[i], 1);
         `CHK(b - a, {24'h0, rows[i].d})
      end
      meas('{16'h0, 4'h0, SEL_COLL, 8'h1}, 2);
      `CHK(b - a, 32'h1)
      selPort = MY_PORT + 6'h1;
      meas('{16'h40, 4'h0, SEL_FRAMES, 8'h1}, 3);
      `CHK(b, 32'h1e)
      selPort = MY_PORT;
      meas('{16'h40, 4'h0, SEL_FRAMES, 8'h1}, 3);
      `CHK(b, 32'h0)
      for (int s = 0; s < 18; s++) begin
         meas('{16'h0, 4'h0, 5'(s), 8'h0}, 0);
         `CHK(b, 32'h0)
      end
      meas('{16'h40, 4'h0, SEL_BIN0, 8'h1}, 1);
      `CHK(b, 32'h1)
      end_of_test();
   end
endmodule
